// ==== cod_decode_top.sv ====
// Purpose: Decode and execute control, inherent and indirect-pointer opcodes
// Assumes: One opcode offered per cycle with instr_valid; data memory answers
//          mem_rdata in the same cycle as mem_rd_r
// Notes: Overview of operation list follows
// Overview of operation
// - W-relative branch, two cycles
// - Call with target from W, two cycles
// - Return placing literal in W, two cycles
// - Load option register from W, one cycle
// - Load selected port direction from W
// - Standby entry sets timeout, clears powerdown
// - Add literal to selected pointer, one cycle
// - Indirect load with pre/post modify, zero flag
// - Indexed indirect load, zero flag from data
// - Indexed indirect store, flags untouched
// - Indirect store with pre/post modify
// - PC-changing opcodes add one no-op cycle
// - Pointer MSb set adds one cycle to indirect loads and stores
// - Literal is signed six-bit, sixteen-bit pair
// - Pointer arithmetic wraps, never saturates
`timescale 1ns/100ps
module cod_decode_top
  import cod_pkg::*;
#(
  parameter int NUM_DIR = 3
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [OP_W-1:0] instr,
  input wire logic [PC_W-1:0] pc_next,
  input wire logic [6:0] pclath,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic wake,
  output logic instr_ready_r,
  output logic exec_nop_r,
  output logic pc_load_r,
  output logic [PC_W-1:0] pc_target_r,
  output logic stack_push_r,
  output logic stack_pop_r,
  output logic [DW-1:0] wreg_r,
  output logic zero_flag_r,
  output logic [DW-1:0] option_r,
  output logic [NUM_DIR*DW-1:0] port_dir_r,
  output logic standby_r,
  output logic timeout_flag_r,
  output logic powerdown_flag_r,
  output logic [PTR_W-1:0] ptr0_r,
  output logic [PTR_W-1:0] ptr1_r,
  output logic [PTR_W-1:0] mem_addr_r,
  output logic mem_rd_r,
  output logic mem_we_r,
  output logic [DW-1:0] mem_wdata_r
);

  // Class hits for the offered opcode
  logic hit_branch_rel, hit_call_wreg, hit_retlit, hit_option, hit_sleep, hit_dir;
  logic hit_padd, hit_iload, hit_istore, hit_xload, hit_xstore;

  cod_op_match #(.MASK(FULL_MASK), .VALUE(BRANCH_REL_WREG_VAL)) u_branch_rel (.opcode(instr),
    .hit(hit_branch_rel));
  cod_op_match #(.MASK(FULL_MASK), .VALUE(CALL_VIA_WREG_VAL)) u_call_wreg (.opcode(instr),
    .hit(hit_call_wreg));
  cod_op_match #(.MASK(RETLIT_MASK), .VALUE(RETLIT_VAL)) u_retlit (.opcode(instr), .hit(hit_retlit));
  cod_op_match #(.MASK(FULL_MASK), .VALUE(OPTION_VAL)) u_option (.opcode(instr), .hit(hit_option));
  cod_op_match #(.MASK(FULL_MASK), .VALUE(SLEEP_VAL)) u_sleep (.opcode(instr), .hit(hit_sleep));
  cod_op_match #(.MASK(DIR_MASK), .VALUE(DIR_VAL)) u_dir (.opcode(instr), .hit(hit_dir));
  cod_op_match #(.MASK(PADD_MASK), .VALUE(PADD_VAL)) u_padd (.opcode(instr), .hit(hit_padd));
  cod_op_match #(.MASK(IMOD_MASK), .VALUE(ILOAD_VAL)) u_iload (.opcode(instr), .hit(hit_iload));
  cod_op_match #(.MASK(IMOD_MASK), .VALUE(ISTORE_VAL)) u_istore (.opcode(instr), .hit(hit_istore));
  cod_op_match #(.MASK(PADD_MASK), .VALUE(XLOAD_VAL)) u_xload (.opcode(instr), .hit(hit_xload));
  cod_op_match #(.MASK(PADD_MASK), .VALUE(XSTORE_VAL)) u_xstore (.opcode(instr), .hit(hit_xstore));

  // Opcode taken this cycle
  wire logic accept = instr_valid & instr_ready_r;

  // Forwarded W and zero: a load issued last cycle lands now, so the
  // next opcode must see the fresh data rather than the stale register
  wire logic [DW-1:0] w_now = mem_rd_r ? mem_rdata : wreg_r;
  wire logic zero_now = mem_rd_r ? (mem_rdata == 8'h00) : zero_flag_r;

  // Grouped classes
  wire logic ind_mod = hit_iload | hit_istore;
  wire logic ind_idx = hit_xload | hit_xstore;
  wire logic ind_any = ind_mod | ind_idx;
  wire logic lit_form = hit_padd | ind_idx;
  wire logic two_cycle = hit_branch_rel | hit_call_wreg | hit_retlit;

  // Pointer pair select bit sits in different places per form
  wire logic sel_n = lit_form ? instr[SEL_BIT_LIT] : instr[SEL_BIT_MOD];
  wire logic [PTR_W-1:0] ptr_sel = sel_n ? ptr1_r : ptr0_r;

  // Modify mode: pre/post and increment/decrement
  wire logic modify_pre = ~instr[MODIFY_PRE_BIT];
  wire logic [LIT_W-1:0] step = instr[MODIFY_DEC_BIT] ? STEP_DEC : STEP_INC;

  // Pointer adders, both wrap through truncation
  logic [PTR_W-1:0] ptr_plus_k;
  logic [PTR_W-1:0] ptr_stepped;

  cod_ptr_add #(.W(PTR_W), .K(LIT_W)) u_add_lit (
    .base(ptr_sel),
    .offset(instr[LIT_W-1:0]),
    .sum(ptr_plus_k)
  );

  cod_ptr_add #(.W(PTR_W), .K(LIT_W)) u_add_step (
    .base(ptr_sel),
    .offset(step),
    .sum(ptr_stepped)
  );

  // Memory address: indexed, pre-modified or the unmodified pointer
  wire logic [PTR_W-1:0] ind_addr = ind_idx ? ptr_plus_k : (modify_pre ? ptr_stepped : ptr_sel);

  // New pointer value, only add and modify forms write back
  wire logic ptr_wr = accept & (hit_padd | ind_mod);
  wire logic [PTR_W-1:0] ptr_new = hit_padd ? ptr_plus_k : ptr_stepped;

  // Upper half of the pointer space costs a cycle; judged on the
  // pointer before any modification
  wire logic msb_extra = ind_any & ptr_sel[PTR_W-1];

  // Port direction index
  wire logic [2:0] dir_off = instr[2:0] - DIR_PORT_FIRST;
  wire logic dir_ok = (instr[2:0] >= DIR_PORT_FIRST) && (int'(dir_off) < NUM_DIR);

  // Branch target from W: relative add or high seven bits from latch
  wire logic [PC_W-1:0] branch_rel_target = pc_next + {7'h00, w_now};
  wire logic [PC_W-1:0] call_wreg_target = {pclath, w_now};
  wire logic pc_take = accept & (hit_branch_rel | hit_call_wreg);
  wire logic [PC_W-1:0] pc_target_nxt = hit_branch_rel ? branch_rel_target : call_wreg_target;

  // Sequencer
  cod_state_e state_r, state_nxt;

  always_comb begin
    state_nxt = ST_RUN;
    unique case (state_r)
      ST_RUN: begin
        if (accept && two_cycle) begin
          state_nxt = ST_NOP;
        end else if (accept && msb_extra) begin
          state_nxt = ST_XTRA;
        end
      end
      ST_NOP: state_nxt = ST_RUN;
      ST_XTRA: state_nxt = ST_RUN;
    endcase
  end

  // Standby: entry wins over a wake in the same cycle
  wire logic standby_nxt = (accept & hit_sleep) | (standby_r & ~wake);
  wire logic ready_nxt = (state_nxt == ST_RUN) & ~standby_nxt;

  // W and zero: landing load data, then W alone overridden by a literal return
  wire logic [DW-1:0] wreg_nxt = (accept & hit_retlit) ? instr[7:0] : w_now;

  // Direction registers
  logic [NUM_DIR*DW-1:0] port_dir_nxt;

  always_comb begin
    port_dir_nxt = port_dir_r;
    for (int i = 0; i < NUM_DIR; i++) begin
      if (accept && hit_dir && dir_ok && int'(dir_off) == i) begin
        port_dir_nxt[i*DW +: DW] = w_now;
      end
    end
  end

  // Sequencer and handshake flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      instr_ready_r <= 1'b0;
      exec_nop_r <= 1'b0;
      standby_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      instr_ready_r <= ready_nxt;
      exec_nop_r <= (state_nxt == ST_NOP);
      standby_r <= standby_nxt;
    end
  end

  // Program flow pulses, target held between loads
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_load_r <= 1'b0;
      pc_target_r <= PC_RST;
      stack_push_r <= 1'b0;
      stack_pop_r <= 1'b0;
    end else begin
      pc_load_r <= pc_take;
      // Target only moves with a load, so it stays readable afterwards
      pc_target_r <= pc_take ? pc_target_nxt : pc_target_r;
      stack_push_r <= accept & hit_call_wreg;
      stack_pop_r <= accept & hit_retlit;
    end
  end

  // Working register, flags and configuration loads
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wreg_r <= WREG_RST;
      zero_flag_r <= 1'b0;
      option_r <= OPTION_RST;
      port_dir_r <= {NUM_DIR{DIR_RST}};
    end else begin
      wreg_r <= wreg_nxt;
      zero_flag_r <= zero_now;
      option_r <= (accept && hit_option) ? w_now : option_r;
      port_dir_r <= port_dir_nxt;
    end
  end

  // Sleep status: timeout set and powerdown cleared on entry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag_r <= TIMEOUT_RST;
      powerdown_flag_r <= POWERDOWN_RST;
    end else if (accept && hit_sleep) begin
      timeout_flag_r <= 1'b1;
      powerdown_flag_r <= 1'b0;
    end
  end

  // Pointer pairs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr0_r <= PTR_RST;
      ptr1_r <= PTR_RST;
    end else if (ptr_wr) begin
      if (sel_n) begin
        ptr1_r <= ptr_new;
      end else begin
        ptr0_r <= ptr_new;
      end
    end
  end

  // Data memory port; stores never touch the zero flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_r <= PTR_RST;
      mem_rd_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_wdata_r <= WREG_RST;
    end else begin
      mem_addr_r <= (accept && ind_any) ? ind_addr : mem_addr_r;
      mem_rd_r <= accept & (hit_iload | hit_xload);
      mem_we_r <= accept & (hit_istore | hit_xstore);
      mem_wdata_r <= w_now;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_take_branch_rel;
    instr_valid && instr_ready_r && instr == BRANCH_REL_WREG_VAL;
  endsequence

  sequence s_nop_slot;
    pc_load_r && exec_nop_r && !instr_ready_r ##1 !exec_nop_r;
  endsequence

  sequence s_take_padd0;
    accept && hit_padd && !instr[SEL_BIT_LIT];
  endsequence

  wire logic [PTR_W-1:0] k_ext = {{(PTR_W-LIT_W){instr[LIT_W-1]}}, instr[LIT_W-1:0]};

  a_branch_rel_target:
    assert property (s_take_branch_rel |=> pc_target_r == $past(branch_rel_target) ##0 s_nop_slot)
    else $error("relative branch target or slot wrong");

  a_call_wreg_push:
    assert property (accept && hit_call_wreg |=> stack_push_r && pc_load_r
                     && pc_target_r == {$past(pclath), $past(w_now)} ##1 !stack_push_r)
    else $error("call via W wrong");

  a_retlit_wreg:
    assert property (accept && hit_retlit |=> stack_pop_r && !instr_ready_r
                     && wreg_r == $past(instr[7:0]))
    else $error("return literal wrong");

  a_option_load:
    assert property (accept && hit_option |=> option_r == $past(w_now)
                     && zero_flag_r == $past(zero_now) && instr_ready_r)
    else $error("option load wrong");

  a_dir_first:
    assert property (accept && hit_dir && instr[2:0] == DIR_PORT_FIRST
                     |=> port_dir_r[DW-1:0] == $past(w_now))
    else $error("direction load wrong");

  a_sleep_flags:
    assert property (accept && hit_sleep |=> standby_r && timeout_flag_r && !powerdown_flag_r
                     && !instr_ready_r)
    else $error("standby entry wrong");

  a_padd_wrap:
    assert property (s_take_padd0 |=> ptr0_r == $past(ptr0_r) + $past(k_ext) && instr_ready_r)
    else $error("pointer add wrong");

  a_load_zero:
    assert property (mem_rd_r |=> zero_flag_r == ($past(mem_rdata) == 8'h00))
    else $error("load zero flag wrong");

  a_store_flags:
    assert property (accept && (hit_istore || hit_xstore) |=> mem_we_r
                     && zero_flag_r == $past(zero_now) && mem_wdata_r == $past(w_now))
    else $error("indirect store wrong");

  a_msb_extra:
    assert property (accept && msb_extra |=> !instr_ready_r ##1 instr_ready_r)
    else $error("extra cycle wrong");

endmodule

// ==== cod_pkg.sv ====
// Purpose: Shared constants for the control and indirect-pointer opcode decoder
// Assumes: 14-bit opcodes, 8-bit working register, 16-bit pointer pairs
// Notes: Opcode classes are given as a care mask plus a match value
package cod_pkg;

  // Datapath widths
  localparam int OP_W = 14;
  localparam int DW = 8;
  localparam int PTR_W = 16;
  localparam int PC_W = 15;
  localparam int LIT_W = 6;

  // Exact opcodes
  localparam logic [13:0] BRANCH_REL_WREG_VAL = 14'h000B;
  localparam logic [13:0] CALL_VIA_WREG_VAL = 14'h000A;
  localparam logic [13:0] OPTION_VAL = 14'h0062;
  localparam logic [13:0] SLEEP_VAL = 14'h0063;
  localparam logic [13:0] FULL_MASK = 14'h3FFF;

  // Masked opcode classes
  localparam logic [13:0] RETLIT_MASK = 14'h3F00;
  localparam logic [13:0] RETLIT_VAL = 14'h3400;
  localparam logic [13:0] DIR_MASK = 14'h3FF8;
  localparam logic [13:0] DIR_VAL = 14'h0060;
  localparam logic [13:0] PADD_MASK = 14'h3F80;
  localparam logic [13:0] PADD_VAL = 14'h3100;
  localparam logic [13:0] IMOD_MASK = 14'h3FF8;
  localparam logic [13:0] ILOAD_VAL = 14'h0010;
  localparam logic [13:0] ISTORE_VAL = 14'h0018;
  localparam logic [13:0] XLOAD_VAL = 14'h3F00;
  localparam logic [13:0] XSTORE_VAL = 14'h3F80;

  // Field positions
  localparam int SEL_BIT_MOD = 2;
  localparam int SEL_BIT_LIT = 6;
  localparam int MODIFY_PRE_BIT = 1;
  localparam int MODIFY_DEC_BIT = 0;

  // Pointer step literals
  localparam logic [5:0] STEP_INC = 6'h01;
  localparam logic [5:0] STEP_DEC = 6'h3F;

  // Port direction registers start at this port field value
  localparam logic [2:0] DIR_PORT_FIRST = 3'h5;

  // Values after reset
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic TIMEOUT_RST = 1'b1;
  localparam logic POWERDOWN_RST = 1'b1;

  // Sequencer states
  typedef enum logic [1:0] {ST_RUN, ST_NOP, ST_XTRA} cod_state_e;

endpackage

// ==== cod_op_match.sv ====
// Purpose: Masked compare of one opcode against one instruction class
// Assumes: Opcode is stable while the decoder samples it
// Notes: Purely combinational, instantiated once per class
`timescale 1ns/100ps
module cod_op_match
  import cod_pkg::*;
#(
  parameter logic [OP_W-1:0] MASK = FULL_MASK,
  parameter logic [OP_W-1:0] VALUE = 14'h0000
)(
  input wire logic [OP_W-1:0] opcode,
  output logic hit
);

  // Don't-care bits are masked off before comparing
  assign hit = ((opcode & MASK) == VALUE);

endmodule

// ==== cod_ptr_add.sv ====
// Purpose: Add a signed short literal to a pointer pair
// Assumes: Offset is two's complement of width K
// Notes: Sum is truncated to W bits, so it wraps at both ends
`timescale 1ns/100ps
module cod_ptr_add #(
  parameter int W = 16,
  parameter int K = 6
)(
  input wire logic [W-1:0] base,
  input wire logic [K-1:0] offset,
  output logic [W-1:0] sum
);

  // Sign extension keeps negative steps correct
  wire logic [W-1:0] offset_ext = {{(W-K){offset[K-1]}}, offset};

  // No saturation: carry out is simply dropped
  assign sum = base + offset_ext;

endmodule

// ==== tb_cod_decode_top.sv ====
// Purpose: Self-checking bench for the control and indirect-pointer opcode decoder
// Assumes: Bench drives every input at the falling edge, outputs read mid-cycle
// Notes: Expected values are worked out here, never read back from the design
`timescale 1ns/100ps
module tb_cod_decode_top;
  import cod_pkg::*;
  logic clk_sys = 1'b0; // 100 MHz system clock
  logic rst_n = 1'b0; // Async reset, active low
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [14:0] pc_next = 15'h0100; // Fixed next address for relative branch
  logic [6:0] pclath = 7'h12; // Fixed high part of the call target
  logic [7:0] mem_rdata = 8'h00;
  logic wake = 1'b0;
  logic instr_ready_r, exec_nop_r, pc_load_r, stack_push_r, stack_pop_r;
  logic [14:0] pc_target_r;
  logic [7:0] wreg_r, option_r, mem_wdata_r;
  logic zero_flag_r, standby_r, timeout_flag_r, powerdown_flag_r, mem_rd_r, mem_we_r;
  logic [23:0] port_dir_r;
  logic [15:0] ptr0_r, ptr1_r, mem_addr_r;
  int err_count = 0; // Mismatches seen
  int num_checks = 0; // Comparisons made
  logic [15:0] p; // Model of pointer pair 1
  logic [7:0] w; // Model of the working register

  cod_decode_top #(.NUM_DIR(3)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .pc_next(pc_next), .pclath(pclath), .mem_rdata(mem_rdata), .wake(wake),
    .instr_ready_r(instr_ready_r), .exec_nop_r(exec_nop_r), .pc_load_r(pc_load_r),
    .pc_target_r(pc_target_r), .stack_push_r(stack_push_r), .stack_pop_r(stack_pop_r),
    .wreg_r(wreg_r), .zero_flag_r(zero_flag_r), .option_r(option_r), .port_dir_r(port_dir_r),
    .standby_r(standby_r), .timeout_flag_r(timeout_flag_r), .powerdown_flag_r(powerdown_flag_r),
    .ptr0_r(ptr0_r), .ptr1_r(ptr1_r), .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r),
    .mem_we_r(mem_we_r), .mem_wdata_r(mem_wdata_r));

  // Free-running clock, 10 ns period
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Single comparison point, four-state exact
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Offer one opcode; returns in cycle 1, where the effects show
  task automatic issue(input logic [13:0] op, input logic [7:0] rd);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (instr_ready_r !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check("ready before issue", instr_ready_r, 1'b1);
    instr_valid = 1'b1;
    instr = op;
    mem_rdata = ~rd; // Not yet valid, so never the real value
    @(negedge clk_sys);
    instr_valid = 1'b0;
    mem_rdata = rd; // Memory answers in the same cycle as the read pulse
  endtask

  // Reset values of the visible state
  task automatic t_reset;
    check("option", option_r, 8'hFF);
    check("port dir", port_dir_r, 24'hFFFFFF);
    check("wreg", wreg_r, 8'h00);
    check("timeout", timeout_flag_r, 1'b1);
    check("powerdown", powerdown_flag_r, 1'b1);
    check("ptr0", ptr0_r, 16'h0000);
  endtask

  // Two-cycle control transfers, W seeded by the literal return
  task automatic t_flow;
    issue(14'h34A5, 8'h00);
    check("pop", stack_pop_r, 1'b1);
    check("wreg", wreg_r, 8'hA5);
    check("nop", exec_nop_r, 1'b1);
    check("ready", instr_ready_r, 1'b0);
    issue(BRANCH_REL_WREG_VAL, 8'h00);
    check("pc load", pc_load_r, 1'b1);
    check("target", pc_target_r, 15'h01A5);
    check("nop", exec_nop_r, 1'b1);
    check("ready", instr_ready_r, 1'b0);
    @(negedge clk_sys);
    check("pc load", pc_load_r, 1'b0);
    issue(CALL_VIA_WREG_VAL, 8'h00);
    check("push", stack_push_r, 1'b1);
    check("target", pc_target_r, 15'h12A5);
    check("ready", instr_ready_r, 1'b0);
  endtask

  // Option and the three direction registers
  task automatic t_config;
    issue(OPTION_VAL, 8'h00);
    check("option", option_r, 8'hA5);
    check("zero", zero_flag_r, 1'b0);
    check("ready", instr_ready_r, 1'b1);
    for (int f = 5; f <= 7; f++) begin
      issue(14'h3400 | 14'(8'h10 + f), 8'h00);
      issue(14'h0060 | 14'(f), 8'h00);
      check("port dir", port_dir_r[(f - 5) * 8 +: 8], 8'(8'h10 + f));
    end
    w = 8'h17;
  endtask

  // Signed literal adds, wrapping at both ends
  task automatic t_ptr_add;
    issue(14'h313F, 8'h00);
    check("ptr0", ptr0_r, 16'hFFFF);
    issue(14'h315F, 8'h00);
    check("ptr1", ptr1_r, 16'h001F);
    check("ready", instr_ready_r, 1'b1);
    issue(14'h3160, 8'h00);
    check("ptr1", ptr1_r, 16'hFFFF);
    issue(14'h3141, 8'h00);
    check("ptr1", ptr1_r, 16'h0000);
    check("zero", zero_flag_r, 1'b0);
    p = 16'h0000;
  endtask

  // All four modify modes on pointer 1, load or store
  task automatic t_modify(input bit st);
    logic [15:0] np, a;
    logic [7:0] d;
    for (int md = 0; md < 4; md++) begin
      np = md[0] ? p - 16'h0001 : p + 16'h0001; // Bit 0 picks decrement
      a = md[1] ? p : np; // Bit 1 picks post-modify
      d = 8'(md * 8'h33);
      issue((st ? ISTORE_VAL : ILOAD_VAL) | 14'h0004 | 14'(md), d);
      check("addr", mem_addr_r, a);
      check("ptr1", ptr1_r, np);
      check("read", mem_rd_r, !st);
      check("write", mem_we_r, st);
      if (st) begin
        check("wdata", mem_wdata_r, w);
        check("zero", zero_flag_r, 1'b0);
      end else begin
        @(negedge clk_sys);
        check("wreg", wreg_r, d);
        check("zero", zero_flag_r, d == 8'h00);
        w = d;
      end
      p = np;
    end
  endtask

  // Indexed forms: pointer plus offset, pointer unchanged
  task automatic t_indexed;
    issue(14'h3F45, 8'h00);
    check("addr", mem_addr_r, 16'h0005);
    check("read", mem_rd_r, 1'b1);
    check("ptr1", ptr1_r, 16'h0000);
    @(negedge clk_sys);
    check("zero", zero_flag_r, 1'b1);
    issue(14'h3477, 8'h00);
    issue(14'h3FC3, 8'h00);
    check("write", mem_we_r, 1'b1);
    check("addr", mem_addr_r, 16'h0003);
    check("wdata", mem_wdata_r, 8'h77);
    check("zero", zero_flag_r, 1'b1);
  endtask

  // Pointer 0 holds FFFF, so its top bit costs a cycle
  task automatic t_extra;
    issue(14'h0012, 8'h00);
    check("ready", instr_ready_r, 1'b0);
    check("addr", mem_addr_r, 16'hFFFF);
    check("ptr0", ptr0_r, 16'h0000);
    @(negedge clk_sys);
    check("ready", instr_ready_r, 1'b1);
  endtask

  // Standby entry, flags, then wake
  task automatic t_standby;
    issue(SLEEP_VAL, 8'h00);
    check("standby", standby_r, 1'b1);
    check("timeout", timeout_flag_r, 1'b1);
    check("powerdown", powerdown_flag_r, 1'b0);
    check("ready", instr_ready_r, 1'b0);
    wake = 1'b1;
    @(negedge clk_sys);
    check("standby", standby_r, 1'b0);
    wake = 1'b0;
  endtask

  // Verdict and end of run, shared with the watchdog
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    t_reset();
    rst_n = 1'b1;
    t_flow();
    t_config();
    t_ptr_add();
    t_modify(1'b0);
    t_modify(1'b1);
    t_indexed();
    t_extra();
    t_standby();
    stop_test();
  end

  // Watchdog, far beyond the fewer than one hundred cycles the run needs
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule
